// >>> verilog/dac_ctrl_defines.svh
// Purpose: Offsets, fields, reset values for the converter control block
// Assumes: Avalon-MM word addressing by byte address, 32-bit data
// Notes: Offset and field list below
`ifndef DAC_CTRL_DEFINES_SVH
`define DAC_CTRL_DEFINES_SVH

`define OFS_CONTROL 4'h0
`define OFS_HIGH 4'h4
`define OFS_LOW 4'h8
`define OFS_SHADOW 4'hc

`define BIT_EN 0
`define BIT_OE 1
`define BIT_LA 2
`define TS_LSB 4
`define BIT_ATE 7

`define RST_BYTE 8'h00
`define RST_VALUE 10'h000

`endif

// >>> verilog/dac_ctrl_pkg.sv
// Purpose: Types for the converter control block
// Assumes: Used with dac_ctrl_defines.svh
// Notes: Control byte layout as packed struct
package dac_ctrl_pkg;

	typedef struct packed {
		logic auto_trigger_enable;
		logic [2:0] trigger_source_select;
		logic rsvd;
		logic left_align_select;
		logic analog_pin_output_enable;
		logic converter_enable;
	} converter_control_t;

	typedef enum logic [1:0] {
		ARM_IDLE,
		ARM_LOW_SEEN
	} arm_state_t;

endpackage : dac_ctrl_pkg

// >>> verilog/dac_input_update_control.sv
// Purpose: Converter input registers, shadow update and trigger logic
// Assumes: Trigger flags come from logic on mclk
// Notes: Bus answers every access with one wait cycle
`include "dac_ctrl_defines.svh"
`timescale 1ns/1ps

module dac_input_update_control (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] trigger_flags,
	output logic [9:0] converter_value,
	output logic converter_enable,
	output logic analog_pin_output_enable
);

	// ****************************************
	// Decode helpers
	// ****************************************
	// Address match for one register offset
	function automatic logic reg_hit(
		input logic [3:0] addr,
		input logic [3:0] ofs
	);
		reg_hit = (addr == ofs);
	endfunction : reg_hit

	// Ten-bit value from the two input bytes
	function automatic logic [9:0] align_value(
		input logic [7:0] hi,
		input logic [7:0] lo,
		input logic left
	);
		if (left) begin
			align_value = {hi, lo[7:6]};
		end else begin
			align_value = {hi[1:0], lo};
		end
	endfunction : align_value

	// One flag picked by the select code
	function automatic logic pick_flag(
		input logic [7:0] flags,
		input logic [2:0] sel
	);
		unique case (sel)
			3'h0: pick_flag = flags[0];
			3'h1: pick_flag = flags[1];
			3'h2: pick_flag = flags[2];
			3'h3: pick_flag = flags[3];
			3'h4: pick_flag = flags[4];
			3'h5: pick_flag = flags[5];
			3'h6: pick_flag = flags[6];
			3'h7: pick_flag = flags[7];
		endcase
	endfunction : pick_flag

	// Read word for one register offset
	function automatic logic [31:0] read_word(
		input logic [3:0] addr,
		input logic [7:0] ctl,
		input logic [7:0] hi,
		input logic [7:0] lo,
		input logic [9:0] shadow
	);
		read_word = 32'h0000_0000;
		if (reg_hit(addr, `OFS_CONTROL)) begin
			read_word = {24'h00_0000, ctl};
		end else if (reg_hit(addr, `OFS_HIGH)) begin
			read_word = {24'h00_0000, hi};
		end else if (reg_hit(addr, `OFS_LOW)) begin
			read_word = {24'h00_0000, lo};
		end else if (reg_hit(addr, `OFS_SHADOW)) begin
			read_word = {22'h0, shadow};
		end
	endfunction : read_word

	// ****************************************
	// Bus slave
	// ****************************************
	logic ack_r;
	logic [31:0] rdata_r;
	logic wr_take;
	logic wr_ctl;
	logic wr_hi;
	logic wr_lo;
	dac_ctrl_pkg::converter_control_t ctl_r;
	dac_ctrl_pkg::converter_control_t ctl_nxt;
	logic [7:0] high_r;
	logic [7:0] high_nxt;
	logic [7:0] low_r;
	logic [7:0] low_nxt;
	logic [9:0] shadow_r;
	logic [9:0] shadow_nxt;
	dac_ctrl_pkg::arm_state_t arm_r;
	dac_ctrl_pkg::arm_state_t arm_nxt;
	logic pending_r;
	logic pending_nxt;
	logic [7:0] flags_q_r;
	logic [7:0] flags_prev_r;
	logic [7:0] flag_rise;
	logic trig_edge;
	logic [9:0] assembled;
	logic load_manual;
	logic load_auto;

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign avs_readdata = rdata_r;

	// One wait cycle per access
	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read | avs_write) & ~ack_r;
		end
	end

	assign wr_take = avs_write & ack_r & avs_byteenable[0];
	assign wr_ctl = wr_take & reg_hit(avs_address, `OFS_CONTROL);
	assign wr_hi = wr_take & reg_hit(avs_address, `OFS_HIGH);
	assign wr_lo = wr_take & reg_hit(avs_address, `OFS_LOW);

	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_r <= 32'h0000_0000;
		end else if (avs_read & ~ack_r) begin
			rdata_r <= read_word(avs_address, ctl_r, high_r, low_r, shadow_r);
		end
	end

	// ****************************************
	// Control register
	// ****************************************
	// Reserved bit three always reads zero
	always_comb begin
		ctl_nxt = ctl_r;
		if (wr_ctl) begin
			ctl_nxt.auto_trigger_enable = avs_writedata[`BIT_ATE];
			ctl_nxt.trigger_source_select = avs_writedata[`TS_LSB +: 3];
			ctl_nxt.rsvd = 1'b0;
			ctl_nxt.left_align_select = avs_writedata[`BIT_LA];
			ctl_nxt.analog_pin_output_enable = avs_writedata[`BIT_OE];
			ctl_nxt.converter_enable = avs_writedata[`BIT_EN];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctl_r <= `RST_BYTE;
		end else begin
			ctl_r <= ctl_nxt;
		end
	end

	// ****************************************
	// Input bytes
	// ****************************************
	always_comb begin
		high_nxt = high_r;
		if (wr_hi) begin
			high_nxt = avs_writedata[7:0];
		end
	end

	always_comb begin
		low_nxt = low_r;
		if (wr_lo) begin
			low_nxt = avs_writedata[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			high_r <= `RST_BYTE;
		end else begin
			high_r <= high_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			low_r <= `RST_BYTE;
		end else begin
			low_r <= low_nxt;
		end
	end

	// ****************************************
	// Trigger select and edge
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			flags_q_r <= 8'h00;
			flags_prev_r <= 8'h00;
		end else begin
			flags_q_r <= trigger_flags;
			flags_prev_r <= flags_q_r;
		end
	end

	// Rising edge per flag, interrupt enables unused
	generate
		for (genvar gi = 0; gi < 8; gi++) begin : g_flag_rise
			assign flag_rise[gi] = flags_q_r[gi] & ~flags_prev_r[gi];
		end
	endgenerate

	assign trig_edge = pick_flag(flag_rise, ctl_r.trigger_source_select);

	// ****************************************
	// Arming
	// ****************************************
	always_comb begin
		arm_nxt = arm_r;
		unique case (arm_r)
			dac_ctrl_pkg::ARM_IDLE: begin
				if (wr_lo) begin
					arm_nxt = dac_ctrl_pkg::ARM_LOW_SEEN;
				end
			end
			dac_ctrl_pkg::ARM_LOW_SEEN: begin
				if (wr_hi) begin
					arm_nxt = dac_ctrl_pkg::ARM_IDLE;
				end
			end
			default: arm_nxt = dac_ctrl_pkg::ARM_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			arm_r <= dac_ctrl_pkg::ARM_IDLE;
		end else begin
			arm_r <= arm_nxt;
		end
	end

	// ****************************************
	// Pending auto update
	// ****************************************
	always_comb begin
		pending_nxt = pending_r;
		if (wr_hi & ctl_r.auto_trigger_enable) begin
			pending_nxt = 1'b1;
		end else if (wr_lo) begin
			pending_nxt = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pending_r <= 1'b0;
		end else begin
			pending_r <= pending_nxt;
		end
	end

	// ****************************************
	// Shadow update
	// ****************************************
	// Alignment read at load time only
	assign assembled = align_value(high_r, low_r, ctl_r.left_align_select);
	assign load_manual = ~ctl_r.auto_trigger_enable & wr_hi;
	// Auto load only when armed
	assign load_auto = ctl_r.auto_trigger_enable & trig_edge & pending_r
		& (arm_r == dac_ctrl_pkg::ARM_IDLE);

	always_comb begin
		shadow_nxt = shadow_r;
		if (load_manual) begin
			shadow_nxt = align_value(avs_writedata[7:0], low_r, ctl_r.left_align_select);
		end else if (load_auto) begin
			shadow_nxt = assembled;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			shadow_r <= `RST_VALUE;
		end else begin
			shadow_r <= shadow_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign converter_value = shadow_r;
	assign converter_enable = ctl_r.converter_enable;
	assign analog_pin_output_enable = ctl_r.analog_pin_output_enable;

endmodule : dac_input_update_control

// >>> verification/dac_ctrl_checker.sv
// Purpose: Port checks for the converter control block
// Assumes: One clock, synchronous reset
// Notes: Bind at foot
`timescale 1ns/1ps
module dac_ctrl_checker (
	input logic mclk,
	input logic rst,
	input logic [3:0] avs_address,
	input logic avs_read,
	input logic avs_write,
	input logic [31:0] avs_readdata,
	input logic avs_waitrequest,
	input logic [7:0] trigger_flags,
	input logic [9:0] converter_value,
	input logic converter_enable,
	input logic analog_pin_output_enable
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	wire wd = avs_write && !avs_waitrequest;
	wire rdn = avs_read && !avs_waitrequest;
	wire cw = wd && avs_address == 4'h0;
	wire hw = wd && avs_address == 4'h4;
	AST_WAIT: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest) else $error("w");
	AST_ANS: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest) else $error("a");
	AST_ONE: assert property (rdn || wd |-> $past(avs_waitrequest)) else $error("o");
	AST_EN_HOLD: assert property ($changed(converter_enable) |-> $past(cw)) else $error("e");
	AST_OE_HOLD: assert property ($changed(analog_pin_output_enable) |-> $past(cw))
		else $error("pin enable changed without control write");
	AST_RD_EN: assert property (rdn && avs_address == 4'h0 |->
		avs_readdata[0] == converter_enable) else $error("r");
	AST_HOLD: assert property ($changed(converter_value) |-> $past(hw) ||
		|($past(trigger_flags, 2) & ~$past(trigger_flags, 3))) else $error("h");
	AST_LOW: assert property (wd && avs_address == 4'h8 |=> $stable(converter_value))
		else $error("l");
	AST_SHADOW: assert property (rdn && avs_address == 4'hc |->
		avs_readdata[9:0] == converter_value) else $error("s");
endmodule : dac_ctrl_checker
bind dac_input_update_control dac_ctrl_checker chk_i (.*);

// >>> verification/testbench.sv
// Purpose: directed bench. Assumes: one wait state. Notes: no random
`timescale 1ns/1ps
module testbench;
	logic mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic converter_enable, analog_pin_output_enable;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [7:0] trigger_flags = 8'h0;
	logic [9:0] converter_value, v = 10'h2ad;
	int n_fail = 0, num_checks = 0;
	dac_input_update_control dut (.*);
	initial forever #12.5 mclk = ~mclk;
	task automatic end_sim;
		$display("fails %0d checks %0d", n_fail, num_checks);
		if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_sim
	task automatic chk(input string s, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask : chk
	logic [31:0] rd;
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge mclk);
		{avs_write, avs_read} <= {w, !w};
		{avs_address, avs_writedata} <= {a, 24'h0, d};
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		{avs_write, avs_read} <= 2'b00;
		@(negedge mclk);
	endtask : bus
	task automatic pulse(input int k);
		@(posedge mclk);
		trigger_flags <= 8'h1 << k;
		@(posedge mclk);
		trigger_flags <= 8'h0;
		repeat (2) @(negedge mclk);
	endtask : pulse
	task automatic t_manual;
		bus(1'b0, 4'h0, 8'h0, rd);
		chk("reset", 32'h0, rd);
		for (int i = 1; i < 4; i++) begin
			bus(1'b1, 4'h0, i[7:0], rd);
			chk("ctrl", i, {analog_pin_output_enable, converter_enable});
		end
		bus(1'b1, 4'h8, 8'h5a, rd);
		bus(1'b1, 4'h4, 8'h02, rd);
		chk("right", 32'h25a, converter_value);
		bus(1'b1, 4'h0, 8'h07, rd);
		chk("align", 32'h25a, converter_value);
		bus(1'b1, 4'h4, 8'hab, rd);
		chk("left", 32'h2ad, converter_value);
		pulse(0);
		chk("manual trig", 32'h2ad, converter_value);
		bus(1'b0, 4'hc, 8'h0, rd);
		chk("shadow", 32'h2ad, rd);
	endtask : t_manual
	task automatic t_auto;
		for (int k = 0; k < 8; k++) begin
			bus(1'b1, 4'h0, {1'b1, k[2:0], 4'h1}, rd);
			bus(1'b1, 4'h8, 8'h30 + k[7:0], rd);
			bus(1'b1, 4'h4, {6'h0, k[1:0]}, rd);
			chk("hold", v, converter_value);
			v = {k[1:0], 8'h30 + k[7:0]};
			pulse(k);
			chk("trig", v, converter_value);
		end
		bus(1'b1, 4'h8, 8'h99, rd);
		pulse(7);
		chk("blocked", v, converter_value);
		bus(1'b1, 4'h4, 8'h01, rd);
		pulse(7);
		chk("armed", 32'h199, converter_value);
		bus(1'b1, 4'h0, 8'hf5, rd);
		bus(1'b1, 4'h4, 8'hc4, rd);
		chk("hold8", 32'h199, converter_value);
		pulse(7);
		chk("eight", 32'h312, converter_value);
		bus(1'b1, 4'h4, 8'h3c, rd);
		pulse(7);
		chk("again", 32'h0f2, converter_value);
	endtask : t_auto
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_manual;
		t_auto;
		end_sim;
	end
	initial begin
		#40000;
		n_fail++;
		end_sim;
	end
endmodule : testbench
